// file: src/afa_pkg.sv
// constants, register map and types of the airflow threshold alarm
// assumes one 40 MHz clock and a plain address/strobe register port
package afa_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int AO_W = 16;
    localparam int DELAY_W = 4;
    localparam int PCT_W = 7;
    localparam int IRQ_W = 3;

    // register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_SETPOINT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_TOL_PCT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_TOL_FLOOR = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h18;

    // control register fields
    localparam int CTRL_LOW_EN = 0;
    localparam int CTRL_HIGH_EN = 1;
    localparam int CTRL_AUTO_RESET = 2;
    localparam int CTRL_ZERO_INHIBIT = 3;
    localparam int CTRL_IDLE_HIGH = 4;
    localparam int CTRL_ROUTE_RELAY = 5;
    localparam int CTRL_PRESSURE = 6;
    localparam int CTRL_MAN_RESET = 7;
    localparam int CTRL_DELAY_LSB = 8;

    // status register fields
    localparam int STAT_OUTSIDE = 0;
    localparam int STAT_ACTIVE = 1;
    localparam int STAT_LOW = 2;
    localparam int STAT_HIGH = 3;
    localparam int STAT_MIN_LSB = 4;

    // interrupt bits
    localparam int IRQ_RAISE = 0;
    localparam int IRQ_CLEAR = 1;
    localparam int IRQ_OUTSIDE = 2;

    // reset values, clamp limits and the percent divisor
    localparam logic RST_LOW_EN = 1'b0;
    localparam logic RST_HIGH_EN = 1'b0;
    localparam logic RST_AUTO_RESET = 1'b1;
    localparam logic RST_ZERO_INHIBIT = 1'b1;
    localparam logic RST_IDLE_HIGH = 1'b1;
    localparam logic [DELAY_W-1:0] RST_DELAY_MIN = 4'h2;
    localparam logic [PCT_W-1:0] RST_TOL_PCT = 7'h0F;
    localparam logic [PCT_W-1:0] TOL_PCT_MIN = 7'h05;
    localparam logic [PCT_W-1:0] TOL_PCT_MAX = 7'h64;
    localparam logic [DATA_W-1:0] RST_TOL_FLOOR = 32'h00000014;
    localparam logic [DATA_W-1:0] RST_SETPOINT = 32'h00000000;
    localparam logic [39:0] PCT_DIV = 40'h0000000064;
    localparam logic [DELAY_W-1:0] DELAY_MAX = 4'hF;

    // binary levels of the second analog output
    localparam logic [AO_W-1:0] AO_FULL = 16'hFFFF;
    localparam logic [AO_W-1:0] AO_ZERO = 16'h0000;

    // timing
    localparam longint CLK_HZ = 40000000;
    localparam longint MINUTE_S = 60;
    localparam logic [31:0] MINUTE_CYCLES = 32'(CLK_HZ * MINUTE_S);

    typedef enum logic [1:0] {ST_NORMAL, ST_OUTSIDE, ST_ACTIVE} afa_state_t;

endpackage : afa_pkg

// file: src/afa_sync3.sv
// three-flop synchroniser with agreement filter for a pin input
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module afa_sync3
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pin_in,
    output logic level_out
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
        end
        else
        begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a change counts only when the second and third stages agree
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            level_out <= 1'b1;
        else if (stage2 == stage3)
            level_out <= stage3;
    end
endmodule : afa_sync3
`default_nettype wire

// file: src/afa_tick_div.sv
// restartable divider giving a one-cycle pulse per elapsed minute
// assumes clr is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module afa_tick_div
#(
    parameter logic [31:0] CYCLES = 32'h00000010
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clr,
    output logic tick
);
    logic [31:0] count;

    // restarting on clr keeps the first minute a full minute
    always_ff @(posedge clk)
    begin
        if (sys_rst || clr)
            count <= 32'h00000000;
        else if (count >= CYCLES - 32'h00000001)
            count <= 32'h00000000;
        else
            count <= count + 32'h00000001;
    end

    assign tick = !clr && (count >= CYCLES - 32'h00000001);
endmodule : afa_tick_div
`default_nettype wire

// file: src/afa_alarm.sv
// airflow threshold alarm: band compare, delay timer, reset handling, outputs
// assumes flow values come from logic on clk; the reset button is a raw pin
`timescale 1ns/1ps
`default_nettype none
module afa_alarm
#(
    parameter logic [31:0] MINUTE_CYCLES = afa_pkg::MINUTE_CYCLES
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [afa_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [afa_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [afa_pkg::DATA_W-1:0] reg_rdata,
    input wire logic signed [afa_pkg::DATA_W-1:0] loc1_airflow,
    input wire logic signed [afa_pkg::DATA_W-1:0] pressure_value,
    input wire logic probe_bidirectional,
    input wire logic airflow_output_zero,
    input wire logic relay_fitted,
    input wire logic manual_reset_btn_n,
    output logic alarm_active,
    output logic display_alarm,
    output logic [afa_pkg::AO_W-1:0] second_analog_output,
    output logic relay_contact_output,
    output logic irq
);
    import afa_pkg::*;

    logic low_alarm_enable;
    logic high_alarm_enable;
    logic auto_reset;
    logic zero_inhibit;
    logic idle_high;
    logic route_relay;
    logic pressure_conversion_select;
    logic [DELAY_W-1:0] delay_min;
    logic signed [DATA_W-1:0] setpoint;
    logic [PCT_W-1:0] tol_pct;
    logic [DATA_W-1:0] tol_floor;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_event;
    logic [PCT_W-1:0] wr_pct;

    afa_state_t state;
    afa_state_t next_state;
    logic [DELAY_W-1:0] minute_cnt;
    logic minute_tick;
    logic btn_level;
    logic btn_level_q;
    logic sw_man_reset;
    logic man_reset;
    logic delay_done;

    logic signed [DATA_W-1:0] measured;
    logic [DATA_W:0] abs_sp;
    logic [39:0] pct_prod;
    logic [39:0] pct_band;
    logic [39:0] tolerance_band;
    logic signed [41:0] lim_low;
    logic signed [41:0] lim_high;
    logic signed [41:0] meas_ext;
    logic low_cond;
    logic high_cond;
    logic inhibited;
    logic out_cond;

    // ---------------- register port ----------------
    assign wr_pct = reg_wdata[PCT_W-1:0];

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            low_alarm_enable <= RST_LOW_EN;
            high_alarm_enable <= RST_HIGH_EN;
            auto_reset <= RST_AUTO_RESET;
            zero_inhibit <= RST_ZERO_INHIBIT;
            idle_high <= RST_IDLE_HIGH;
            route_relay <= 1'b0;
            pressure_conversion_select <= 1'b0;
            delay_min <= RST_DELAY_MIN;
        end
        else if (reg_wr && reg_addr == ADDR_CTRL)
        begin
            low_alarm_enable <= reg_wdata[CTRL_LOW_EN];
            high_alarm_enable <= reg_wdata[CTRL_HIGH_EN];
            auto_reset <= reg_wdata[CTRL_AUTO_RESET];
            zero_inhibit <= reg_wdata[CTRL_ZERO_INHIBIT];
            idle_high <= reg_wdata[CTRL_IDLE_HIGH];
            route_relay <= reg_wdata[CTRL_ROUTE_RELAY];
            pressure_conversion_select <= reg_wdata[CTRL_PRESSURE];
            delay_min <= reg_wdata[CTRL_DELAY_LSB +: DELAY_W];
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            setpoint <= RST_SETPOINT;
            tol_pct <= RST_TOL_PCT;
            tol_floor <= RST_TOL_FLOOR;
        end
        else if (reg_wr)
        begin
            if (reg_addr == ADDR_SETPOINT)
                setpoint <= reg_wdata;
            if (reg_addr == ADDR_TOL_PCT)
            begin
                // out-of-range percentages are clamped rather than refused
                if (wr_pct > TOL_PCT_MAX || reg_wdata[DATA_W-1:PCT_W] != '0)
                    tol_pct <= TOL_PCT_MAX;
                else if (wr_pct < TOL_PCT_MIN)
                    tol_pct <= TOL_PCT_MIN;
                else
                    tol_pct <= wr_pct;
            end
            if (reg_addr == ADDR_TOL_FLOOR)
                tol_floor <= reg_wdata;
        end
    end

    assign sw_man_reset = reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_MAN_RESET];

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_mask <= '0;
        else if (reg_wr && reg_addr == ADDR_IRQ_MASK)
            irq_mask <= reg_wdata[IRQ_W-1:0];
    end

    // a new event in the clearing cycle survives the write-one-to-clear
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_status <= '0;
        else if (reg_wr && reg_addr == ADDR_IRQ_STATUS)
            irq_status <= (irq_status & ~reg_wdata[IRQ_W-1:0]) | irq_event;
        else
            irq_status <= irq_status | irq_event;
    end

    assign irq = |(irq_status & irq_mask);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            case (reg_addr)
                ADDR_CTRL: reg_rdata <= {20'h00000, delay_min, 1'b0, pressure_conversion_select, route_relay,
                                         idle_high, zero_inhibit, auto_reset, high_alarm_enable,
                                         low_alarm_enable};
                ADDR_SETPOINT: reg_rdata <= setpoint;
                ADDR_TOL_PCT: reg_rdata <= {25'h0000000, tol_pct};
                ADDR_TOL_FLOOR: reg_rdata <= tol_floor;
                ADDR_STATUS: reg_rdata <= {24'h000000, minute_cnt, high_cond, low_cond, alarm_active, out_cond};
                ADDR_IRQ_STATUS: reg_rdata <= {29'h00000000, irq_status};
                ADDR_IRQ_MASK: reg_rdata <= {29'h00000000, irq_mask};
                default: reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end

    // ---------------- band compare ----------------
    // the second location never reaches this block
    always_comb
    begin
        if (probe_bidirectional && pressure_conversion_select)
            measured = pressure_value;
        else
            measured = loc1_airflow;
    end

    // band is a share of the setpoint magnitude, never below the floor
    assign abs_sp = setpoint[DATA_W-1] ? 33'(-{setpoint[DATA_W-1], setpoint}) : {1'b0, setpoint};
    assign pct_prod = 40'(abs_sp) * 40'(tol_pct);
    assign pct_band = pct_prod / PCT_DIV;
    assign tolerance_band = (pct_band > 40'(tol_floor)) ? pct_band : 40'(tol_floor);

    assign meas_ext = 42'(measured);
    assign lim_low = 42'(setpoint) - $signed({2'b00, tolerance_band});
    assign lim_high = 42'(setpoint) + $signed({2'b00, tolerance_band});
    assign low_cond = low_alarm_enable && (meas_ext < lim_low);
    assign high_cond = high_alarm_enable && (meas_ext > lim_high);
    assign inhibited = zero_inhibit && airflow_output_zero;
    assign out_cond = (low_cond || high_cond) && !inhibited;

    // ---------------- manual reset ----------------
    afa_sync3 u_btn_sync
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(manual_reset_btn_n),
        .level_out(btn_level)
    );

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            btn_level_q <= 1'b1;
        else
            btn_level_q <= btn_level;
    end

    assign man_reset = sw_man_reset || (btn_level_q && !btn_level);

    // ---------------- delay timer ----------------
    afa_tick_div #(.CYCLES(MINUTE_CYCLES)) u_minute
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .clr(state != ST_OUTSIDE),
        .tick(minute_tick)
    );

    always_ff @(posedge clk)
    begin
        if (sys_rst || next_state != ST_OUTSIDE)
            minute_cnt <= '0;
        else if (minute_tick && minute_cnt != DELAY_MAX)
            minute_cnt <= minute_cnt + 4'h1;
    end

    assign delay_done = minute_cnt >= delay_min;

    // ---------------- alarm state ----------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_NORMAL:
                if (out_cond)
                    next_state = ST_OUTSIDE;
            ST_OUTSIDE:
                if (!out_cond)
                    next_state = ST_NORMAL;
                else if (delay_done)
                    next_state = ST_ACTIVE;
            ST_ACTIVE:
                if (auto_reset && !out_cond)
                    next_state = ST_NORMAL;
            default:
                next_state = ST_NORMAL;
        endcase
        // a still-bad flow goes outside again the cycle after it returns to normal, with a fresh timer
        if (man_reset)
            next_state = ST_NORMAL;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            state <= ST_NORMAL;
        else
            state <= next_state;
    end

    assign alarm_active = state == ST_ACTIVE;
    assign display_alarm = alarm_active;

    assign irq_event[IRQ_RAISE] = state != ST_ACTIVE && next_state == ST_ACTIVE;
    assign irq_event[IRQ_CLEAR] = state == ST_ACTIVE && next_state != ST_ACTIVE;
    assign irq_event[IRQ_OUTSIDE] = state == ST_NORMAL && next_state == ST_OUTSIDE;

    // ---------------- outputs ----------------
    // the analog output idles at zero while the relay owns the alarm
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            second_analog_output <= RST_IDLE_HIGH ? AO_FULL : AO_ZERO;
        else if (route_relay && relay_fitted)
            second_analog_output <= AO_ZERO;
        else if (alarm_active)
            second_analog_output <= idle_high ? AO_ZERO : AO_FULL;
        else if (idle_high)
            second_analog_output <= AO_FULL;
        else
            second_analog_output <= AO_ZERO;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            relay_contact_output <= 1'b0;
        else
            relay_contact_output <= route_relay && relay_fitted && alarm_active;
    end

    // ---------------- checks ----------------
    AST_LOW_OUTSIDE: assert property (@(posedge clk) disable iff (sys_rst)
        (low_alarm_enable && !inhibited && meas_ext < lim_low) |-> out_cond)
        else $error("low excursion not treated as outside");

    AST_HIGH_OUTSIDE: assert property (@(posedge clk) disable iff (sys_rst)
        (high_alarm_enable && !inhibited && meas_ext > lim_high) |-> out_cond)
        else $error("high excursion not treated as outside");

    AST_RAISE_AFTER_DELAY: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(alarm_active) |-> $past(state) == ST_OUTSIDE && $past(minute_cnt) >= $past(delay_min))
        else $error("alarm raised before delay expired");

    AST_MANUAL_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        (alarm_active && !auto_reset && !man_reset) |=> alarm_active)
        else $error("manual mode alarm cleared without reset");

    AST_AUTO_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
        (alarm_active && auto_reset && !out_cond) |=> !alarm_active)
        else $error("auto mode alarm did not clear");

    AST_ZERO_INHIBIT: assert property (@(posedge clk) disable iff (sys_rst)
        (zero_inhibit && airflow_output_zero) |-> !out_cond)
        else $error("alarming not suppressed at zero output");

    AST_RESET_DEFAULTS: assert property (@(posedge clk)
        sys_rst |=> !low_alarm_enable && !high_alarm_enable && delay_min == RST_DELAY_MIN)
        else $error("enables or delay wrong after reset");

    AST_AO_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
        (!alarm_active && !(route_relay && relay_fitted) && !$past(sys_rst)) |=>
        second_analog_output == ($past(idle_high) ? AO_FULL : AO_ZERO))
        else $error("analog output not at idle level");

    AST_TIMER_RESTART: assert property (@(posedge clk) disable iff (sys_rst)
        (state == ST_OUTSIDE && !out_cond) |=> state == ST_NORMAL && minute_cnt == '0)
        else $error("delay timer did not restart");

    AST_MANUAL_RESET: assert property (@(posedge clk) disable iff (sys_rst)
        (man_reset && out_cond) |=> state == ST_NORMAL ##1 (state == ST_OUTSIDE || !$past(out_cond)))
        else $error("manual reset did not return to normal then outside");

    COV_RAISE: cover property (@(posedge clk) disable iff (sys_rst) $rose(alarm_active));
    COV_AUTO_CLEAR: cover property (@(posedge clk) disable iff (sys_rst) $fell(alarm_active) && auto_reset);
    COV_MAN_RETRIGGER: cover property (@(posedge clk) disable iff (sys_rst)
        alarm_active && man_reset && out_cond ##2 state == ST_OUTSIDE);
    COV_RELAY: cover property (@(posedge clk) disable iff (sys_rst) $rose(relay_contact_output));
endmodule : afa_alarm
`default_nettype wire

// file: sim/afa_bac_reader.sv
// building automation controller that reads the alarm off the second analog output or the relay
// assumes it samples on the alarm block's clock and knows the idle level and routing that were set
`timescale 1ns/1ps
`default_nettype none
module afa_bac_reader
(
    input wire logic clk,
    input wire logic [15:0] ao_level,
    input wire logic relay_closed,
    input wire logic idle_high,
    input wire logic use_relay,
    output logic alarm_seen
);
    // only the top bit is read: the output is two-level, so a mid-scale code would be a wiring fault
    always_ff @(posedge clk)
    begin
        alarm_seen <= use_relay ? relay_closed : (ao_level[15] != idle_high);
    end
endmodule : afa_bac_reader
`default_nettype wire

// file: sim/afa_alarm_test.sv
// self-checking bench of the airflow threshold alarm with a controller model on its outputs
// assumes a shortened minute of 20 clocks so delays of one minute finish quickly
`timescale 1ns/1ps
`default_nettype none
module afa_alarm_test;
    import afa_pkg::*;
    typedef struct {logic [31:0] sp; logic [31:0] fl; logic [31:0] pr; logic bi; logic [7:0] en; logic ex;} afa_row_t;
    logic clk, sys_rst, reg_wr, reg_rd, bi, zero, fitted, btn_n, active, disp, relay, irq, seen, use_relay, idle_high;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, flow, pres;
    logic [15:0] ao;
    int n_fail, n_tests;
    // setpoint 1000 gives a band of 150, setpoint 100 falls back to the floor of 20
    afa_row_t rows [10] = '{'{32'h3E8, 32'h351, 32'h0, 1'b0, 8'h01, 1'b1}, '{32'h3E8, 32'h352, 32'h0, 1'b0, 8'h01, 1'b0},
        '{32'h3E8, 32'h47F, 32'h0, 1'b0, 8'h02, 1'b1}, '{32'h3E8, 32'h47E, 32'h0, 1'b0, 8'h03, 1'b0},
        '{32'h3E8, 32'h351, 32'h0, 1'b0, 8'h02, 1'b0}, '{32'h64, 32'h4F, 32'h0, 1'b0, 8'h01, 1'b1},
        '{32'h64, 32'h50, 32'h0, 1'b0, 8'h01, 1'b0}, '{32'h3E8, 32'h3E8, 32'h320, 1'b1, 8'h41, 1'b1},
        '{32'h3E8, 32'h320, 32'h3E8, 1'b1, 8'h41, 1'b0}, '{32'h3E8, 32'h320, 32'h3E8, 1'b0, 8'h41, 1'b1}};

    afa_alarm #(.MINUTE_CYCLES(32'h14)) u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loc1_airflow(flow),
        .pressure_value(pres), .probe_bidirectional(bi), .airflow_output_zero(zero), .relay_fitted(fitted),
        .manual_reset_btn_n(btn_n), .alarm_active(active), .display_alarm(disp),
        .second_analog_output(ao), .relay_contact_output(relay), .irq(irq));
    afa_bac_reader u_bac (.clk(clk), .ao_level(ao), .relay_closed(relay), .idle_high(idle_high),
        .use_relay(use_relay), .alarm_seen(seen));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic setin(input logic [31:0] f, input logic [31:0] p, input logic b, input logic z);
        @(posedge clk);
        flow <= f;
        pres <= p;
        bi <= b;
        zero <= z;
    endtask : setin

    task automatic wait_al(input logic exp, input int lim);
        int i;
        i = 0;
        while (active !== exp && i < lim)
        begin
            cyc(1);
            i++;
        end
        chk(active, exp);
    endtask : wait_al

    // the pin is held long enough to pass the agreement filter
    task automatic press();
        @(posedge clk);
        btn_n <= 1'b0;
        repeat (10) @(posedge clk);
        btn_n <= 1'b1;
    endtask : press

    initial
    begin
        logic [31:0] d;
        {reg_wr, reg_rd, bi, zero, fitted, use_relay} = 6'h00;
        {btn_n, idle_high, sys_rst} = 3'h7;
        {reg_addr, reg_wdata, flow, pres} = '0;
        n_fail = 0;
        n_tests = 0;
        cyc(5);
        chk(active, 1'b0);
        chk(ao, AO_FULL);
        chk(irq, 1'b0);
        @(posedge clk);
        sys_rst <= 1'b0;
        rd(ADDR_CTRL, d);
        chk(d, 32'h21C);
        rd(ADDR_TOL_PCT, d);
        chk(d, 32'hF);
        rd(ADDR_TOL_FLOOR, d);
        chk(d, 32'h14);
        rd(8'h1C, d);
        chk(d, 32'h0);
        wr(ADDR_TOL_PCT, 32'h0);
        rd(ADDR_TOL_PCT, d);
        chk(d, 32'h5);
        wr(ADDR_TOL_PCT, 32'h7F);
        rd(ADDR_TOL_PCT, d);
        chk(d, 32'h64);
        wr(ADDR_TOL_PCT, 32'h80);
        rd(ADDR_TOL_PCT, d);
        chk(d, 32'h64);
        wr(ADDR_TOL_PCT, 32'hF);
        wr(ADDR_IRQ_MASK, 32'h7);
        // fifteen-minute delay keeps the band rows from ever raising the alarm
        foreach (rows[i])
        begin
            wr(ADDR_SETPOINT, rows[i].sp);
            wr(ADDR_CTRL, 32'hF04 | {24'h0, rows[i].en});
            setin(rows[i].fl, rows[i].pr, rows[i].bi, 1'b0);
            cyc(3);
            rd(ADDR_STATUS, d);
            chk(d[STAT_OUTSIDE], rows[i].ex);
            chk(active, 1'b0);
        end
        // last row is still outside: let one minute pass, then drop back to normal
        cyc(25);
        rd(ADDR_STATUS, d);
        chk(d, 32'h15);
        setin(32'h3E8, 32'h0, 1'b0, 1'b0);
        cyc(2);
        rd(ADDR_STATUS, d);
        chk(d, 32'h0);
        wr(ADDR_CTRL, 32'h115);
        wr(ADDR_IRQ_STATUS, 32'h7);
        setin(32'h320, 32'h0, 1'b0, 1'b0);
        cyc(18);
        chk(active, 1'b0);
        wait_al(1'b1, 10);
        cyc(2);
        chk(ao, AO_ZERO);
        chk(disp, 1'b1);
        chk(seen, 1'b1);
        chk(irq, 1'b1);
        rd(ADDR_IRQ_STATUS, d);
        chk(d, 32'h5);
        wr(ADDR_IRQ_STATUS, 32'h5);
        rd(ADDR_IRQ_STATUS, d);
        chk(d, 32'h0);
        chk(irq, 1'b0);
        setin(32'h3E8, 32'h0, 1'b0, 1'b0);
        wait_al(1'b0, 4);
        cyc(2);
        chk(ao, AO_FULL);
        rd(ADDR_IRQ_STATUS, d);
        chk(d, 32'h2);
        setin(32'h320, 32'h0, 1'b0, 1'b0);
        cyc(10);
        setin(32'h3E8, 32'h0, 1'b0, 1'b0);
        cyc(3);
        setin(32'h320, 32'h0, 1'b0, 1'b0);
        cyc(18);
        chk(active, 1'b0);
        wait_al(1'b1, 10);
        press();
        wait_al(1'b0, 3);
        cyc(8);
        chk(active, 1'b0);
        wait_al(1'b1, 20);
        setin(32'h3E8, 32'h0, 1'b0, 1'b0);
        wr(ADDR_CTRL, 32'h022);
        idle_high <= 1'b0;
        use_relay <= 1'b1;
        fitted <= 1'b1;
        setin(32'h47F, 32'h0, 1'b0, 1'b0);
        wait_al(1'b1, 5);
        cyc(2);
        chk(relay, 1'b1);
        chk(ao, AO_ZERO);
        chk(seen, 1'b1);
        setin(32'h3E8, 32'h0, 1'b0, 1'b0);
        cyc(10);
        chk(active, 1'b1);
        wr(ADDR_CTRL, 32'h0A2);
        wait_al(1'b0, 3);
        cyc(2);
        chk(relay, 1'b0);
        wr(ADDR_CTRL, 32'h002);
        use_relay <= 1'b0;
        setin(32'h47F, 32'h0, 1'b0, 1'b0);
        wait_al(1'b1, 5);
        cyc(2);
        chk(ao, AO_FULL);
        chk(seen, 1'b1);
        setin(32'h3E8, 32'h0, 1'b0, 1'b0);
        press();
        wait_al(1'b0, 5);
        cyc(2);
        chk(ao, AO_ZERO);
        wr(ADDR_CTRL, 32'h00D);
        setin(32'h0, 32'h0, 1'b0, 1'b1);
        cyc(10);
        chk(active, 1'b0);
        setin(32'h0, 32'h0, 1'b0, 1'b0);
        wait_al(1'b1, 5);
        setin(32'h3E8, 32'h0, 1'b0, 1'b0);
        wait_al(1'b0, 5);
        end_of_test();
    end

    // the sequence needs under 2000 clocks; 20000 leaves ample margin
    initial
    begin
        #500000;
        n_fail++;
        end_of_test();
    end
endmodule : afa_alarm_test
`default_nettype wire
